// ---- cmd_pkg.sv ----
// Purpose: Shared constants and types for the mode and address decoder.
// Assumes: 32-bit logical addresses, 29-bit external memory addresses.
// Notes: All fields, the status word and vector base reset values and the reset vector live here.
package cmd_pkg;

	// Address widths
	localparam int ADDR_W = 32;
	localparam int EXT_W = 29;

	// Reset handler entry and vector base after reset
	localparam logic [31:0] RESET_VECTOR = 32'hA000_0000;
	localparam logic [31:0] VBASE_RESET = 32'h0000_0000;

	// Area select field: upper three address bits
	localparam int AREA_HI = 31;
	localparam int AREA_LO = 29;
	localparam logic [2:0] AREA_CACHED_DIRECT = 3'h4;
	localparam logic [2:0] AREA_UNCACHED_DIRECT = 3'h5;
	localparam logic [2:0] AREA_CACHED_XLATE = 3'h6;
	localparam logic [2:0] AREA_CONTROL = 3'h7;

	// Status word field positions and reset value
	localparam int SW_MODE_BIT = 30;
	localparam int SW_BANK_BIT = 29;
	localparam int SW_BLOCK_BIT = 28;
	localparam int SW_IMASK_HI = 7;
	localparam int SW_IMASK_LO = 4;
	localparam logic [31:0] SW_RESET = 32'h7000_00F0;

	// Control register selectors for privileged writes
	localparam logic [1:0] CTL_SEL_SW = 2'h0;
	localparam logic [1:0] CTL_SEL_SPC = 2'h1;
	localparam logic [1:0] CTL_SEL_SSW = 2'h2;
	localparam logic [1:0] CTL_SEL_VB = 2'h3;

	// Decoded area of a logical address
	typedef enum logic [2:0] {
		CMD_AREA_LOW = 3'h0,
		CMD_AREA_CDIR = 3'h1,
		CMD_AREA_UDIR = 3'h2,
		CMD_AREA_CXL = 3'h3,
		CMD_AREA_CTRL = 3'h4
	} cmd_area_t;

	// Processing state, Gray coded along reset, run, exception, run
	typedef enum logic [1:0] {
		CMD_ST_RESET = 2'h0,
		CMD_ST_RUN = 2'h1,
		CMD_ST_EXC = 2'h3,
		CMD_ST_SLEEP = 2'h2
	} cmd_state_t;

	// Access request from the core
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
	} cmd_req_t;

	// Attributes issued toward cache, translation unit and bus controller
	typedef struct packed {
		logic valid;
		logic cacheable;
		logic translate;
		logic ext_cycle;
		logic control;
		logic [28:0] ext_addr;
	} cmd_acc_t;

endpackage

// ---- cmd_area_decode.sv ----
// Purpose: Combinational decode of one logical address into its area.
// Assumes: Mode bit set means privileged.
// Notes: Feeds the registered issue stage of the decoder top.
`timescale 1ns/1ps
module cmd_area_decode
	import cmd_pkg::*;
(
	input wire logic [31:0] addr_i,
	input wire logic priv_i,
	input wire logic cache_en_i,
	input wire logic xlate_en_i,
	output cmd_area_t area_o,
	output logic cacheable_o,
	output logic translate_o,
	output logic ext_cycle_o,
	output logic violation_o,
	output logic [28:0] ext_addr_o
);

	// Area lookup and attributes
	always_comb begin
		area_o = CMD_AREA_LOW;
		cacheable_o = cache_en_i;
		translate_o = xlate_en_i;
		ext_cycle_o = 1'b1;
		if (addr_i[AREA_HI] == 1'b0) begin
			// Lower half: the only area open to user mode
			area_o = CMD_AREA_LOW;
		end else begin
			case (addr_i[AREA_HI:AREA_LO])
				AREA_CACHED_DIRECT: begin
					area_o = CMD_AREA_CDIR;
					translate_o = 1'b0;
				end
				AREA_UNCACHED_DIRECT: begin
					area_o = CMD_AREA_UDIR;
					cacheable_o = 1'b0;
					translate_o = 1'b0;
				end
				AREA_CACHED_XLATE: begin
					area_o = CMD_AREA_CXL;
				end
				AREA_CONTROL: begin
					area_o = CMD_AREA_CTRL;
					cacheable_o = 1'b0;
					translate_o = 1'b0;
					ext_cycle_o = 1'b0;
				end
				default: begin
					area_o = CMD_AREA_LOW;
				end
			endcase
		end
		// User mode outside the low area is an address error
		violation_o = !priv_i && (area_o != CMD_AREA_LOW);
	end

	// Upper three bits masked for the external address
	assign ext_addr_o = addr_i[EXT_W-1:0];

endmodule

// ---- cmd_mode_decoder.sv ----
// Purpose: CPU processing state, mode and logical address decoder.
// Assumes: Core gives one-cycle event pulses; all inputs on clk_i.
// Notes: Power-on and manual resets both reinitialise this logic.
`timescale 1ns/1ps
module cmd_mode_decoder
	import cmd_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic manual_rst_i,
	input wire cmd_req_t req_i,
	input wire logic cache_en_i,
	input wire logic xlate_en_i,
	input wire logic exc_i,
	input wire logic [11:0] exc_offset_i,
	input wire logic [31:0] pc_i,
	input wire logic trap_i,
	input wire logic rte_i,
	input wire logic sleep_i,
	input wire logic wake_i,
	input wire logic ctl_wr_i,
	input wire logic [1:0] ctl_sel_i,
	input wire logic [31:0] ctl_wdata_i,
	input wire logic sys_instr_i,
	output cmd_acc_t acc_o,
	output logic addr_error_o,
	output logic priv_error_o,
	output logic branch_o,
	output logic [31:0] branch_pc_o,
	output logic [31:0] status_word_o,
	output logic [31:0] saved_program_counter_o,
	output logic [31:0] saved_status_word_o,
	output logic [31:0] vector_base_o,
	output logic processing_mode_bit_o,
	output logic bsc_keep_o,
	output cmd_state_t state_o
);

	// State and control registers
	cmd_state_t state, next_state;
	logic [31:0] status_word, next_status_word;
	logic [31:0] saved_program_counter, next_spc;
	logic [31:0] ssw, next_ssw;
	logic [31:0] vbase, next_vbase;
	logic branch, next_branch;
	logic [31:0] branch_pc, next_branch_pc;
	logic priv_error, next_priv_error;
	logic bsc_keep, next_bsc_keep;
	logic any_rst;

	// Access issue stage
	cmd_acc_t acc, next_acc;
	logic addr_error, next_addr_error;

	// Decoder results
	cmd_area_t dec_area;
	logic dec_cache, dec_xlate, dec_ext, dec_viol;
	logic [28:0] dec_ext_addr;
	logic priv;

	assign any_rst = sys_rst_i || manual_rst_i;
	assign priv = status_word[SW_MODE_BIT];

	// Area decode of the current request
	cmd_area_decode u_dec (
		.addr_i(req_i.addr),
		.priv_i(priv),
		.cache_en_i(cache_en_i),
		.xlate_en_i(xlate_en_i),
		.area_o(dec_area),
		.cacheable_o(dec_cache),
		.translate_o(dec_xlate),
		.ext_cycle_o(dec_ext),
		.violation_o(dec_viol),
		.ext_addr_o(dec_ext_addr)
	);

	// Next state of processing state and control registers
	always_comb begin
		next_state = state;
		next_status_word = status_word;
		next_spc = saved_program_counter;
		next_ssw = ssw;
		next_vbase = vbase;
		next_branch = 1'b0;
		next_branch_pc = branch_pc;
		next_priv_error = 1'b0;
		next_bsc_keep = bsc_keep;
		case (state)
			CMD_ST_RESET: begin
				// Leave reset by fetching the reset handler
				next_state = CMD_ST_RUN;
				next_branch = 1'b1;
				next_branch_pc = RESET_VECTOR;
			end
			CMD_ST_RUN: begin
				if (exc_i || trap_i) begin
					// Exception entry is the only way up
					next_state = CMD_ST_EXC;
					next_spc = pc_i;
					next_ssw = status_word;
					next_status_word[SW_MODE_BIT] = 1'b1;
					next_status_word[SW_BLOCK_BIT] = 1'b1;
					next_status_word[SW_BANK_BIT] = 1'b1;
					next_branch = 1'b1;
					next_branch_pc = vbase + {20'h0_0000, exc_offset_i};
				end else if (rte_i && priv) begin
					// Return restores mode and resumes
					next_status_word = ssw;
					next_branch = 1'b1;
					next_branch_pc = saved_program_counter;
				end else if ((rte_i || sys_instr_i || ctl_wr_i || sleep_i)
						&& !priv) begin
					// Protected instruction or register in user mode
					next_priv_error = 1'b1;
				end else if (sleep_i) begin
					next_state = CMD_ST_SLEEP;
				end else if (ctl_wr_i) begin
					case (ctl_sel_i)
						CTL_SEL_SW: next_status_word = ctl_wdata_i;
						CTL_SEL_SPC: next_spc = ctl_wdata_i;
						CTL_SEL_SSW: next_ssw = ctl_wdata_i;
						CTL_SEL_VB: next_vbase = ctl_wdata_i;
						default: next_vbase = vbase;
					endcase
				end
			end
			CMD_ST_EXC: begin
				// One cycle of exception entry, then run handler
				next_state = CMD_ST_RUN;
			end
			CMD_ST_SLEEP: begin
				// CPU halted until a wakeup event
				if (wake_i) begin
					next_state = CMD_ST_RUN;
				end
			end
			default: begin
				next_state = CMD_ST_RESET;
			end
		endcase
		if (any_rst) begin
			// Both resets reinitialise the CPU, privileged mode
			next_state = CMD_ST_RESET;
			next_status_word = SW_RESET;
			next_vbase = VBASE_RESET;
			next_spc = 32'h0000_0000;
			next_ssw = 32'h0000_0000;
			next_branch = 1'b0;
			next_branch_pc = RESET_VECTOR;
			next_priv_error = 1'b0;
			next_bsc_keep = manual_rst_i && !sys_rst_i;
		end
	end

	// Register the processing state group
	always_ff @(posedge clk_i) begin
		state <= next_state;
		status_word <= next_status_word;
		saved_program_counter <= next_spc;
		ssw <= next_ssw;
		vbase <= next_vbase;
		branch <= next_branch;
		branch_pc <= next_branch_pc;
		priv_error <= next_priv_error;
		bsc_keep <= next_bsc_keep;
	end

	// Next value of the issued access
	always_comb begin
		next_acc = '0;
		next_addr_error = 1'b0;
		if (!any_rst && state == CMD_ST_RUN && req_i.valid) begin
			if (dec_viol) begin
				// Error raised; nothing goes to cache, MMU or bus
				next_addr_error = 1'b1;
			end else begin
				next_acc.valid = 1'b1;
				next_acc.cacheable = dec_cache;
				next_acc.translate = dec_xlate;
				next_acc.ext_cycle = dec_ext;
				next_acc.control = (dec_area == CMD_AREA_CTRL);
				next_acc.ext_addr = dec_ext_addr;
			end
		end
	end

	// Register the access issue stage
	always_ff @(posedge clk_i) begin
		acc <= next_acc;
		addr_error <= next_addr_error;
	end

	assign acc_o = acc;
	assign addr_error_o = addr_error;
	assign priv_error_o = priv_error;
	assign branch_o = branch;
	assign branch_pc_o = branch_pc;
	assign status_word_o = status_word;
	assign saved_program_counter_o = saved_program_counter;
	assign saved_status_word_o = ssw;
	assign vector_base_o = vbase;
	assign processing_mode_bit_o = status_word[SW_MODE_BIT];
	assign bsc_keep_o = bsc_keep;
	assign state_o = state;

	// User-mode access outside the low area errors, never issues
	AST_USER_ERR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state == CMD_ST_RUN && req_i.valid && !manual_rst_i && !priv
		&& req_i.addr[AREA_HI]) |=> (addr_error && !acc.valid))
		else $error("user access outside low area not refused");

	// Privileged access issues with masked address
	AST_EXT_ADDR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state == CMD_ST_RUN && req_i.valid && !manual_rst_i && priv)
		|=> (acc.valid && acc.ext_addr == $past(req_i.addr[28:0])))
		else $error("external address not lower 29 bits");

	AST_CTRL_NOEXT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		acc.valid && acc.control |-> !acc.ext_cycle && !acc.cacheable)
		else $error("control area produced external cycle");

	AST_UNCACHED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state == CMD_ST_RUN && req_i.valid && !manual_rst_i && priv
		&& req_i.addr[31:29] == AREA_UNCACHED_DIRECT)
		|=> acc.valid && !acc.cacheable && !acc.translate && acc.ext_cycle)
		else $error("uncached direct area attributes wrong");

	// Reset release leads to a reset-vector branch
	sequence s_reset_release;
		sys_rst_i ##1 !sys_rst_i && !manual_rst_i;
	endsequence
	AST_RESET_VEC: assert property (@(posedge clk_i)
		s_reset_release |=> branch && branch_pc == RESET_VECTOR
		&& processing_mode_bit_o)
		else $error("reset did not branch to reset vector");

	// Exception entry saves PC and status, branches via vector base
	sequence s_exc_entry;
		state == CMD_ST_RUN && exc_i && !manual_rst_i;
	endsequence
	AST_EXC_SAVE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_exc_entry |=> saved_program_counter == $past(pc_i) && ssw == $past(status_word))
		else $error("exception entry did not save context");

	AST_EXC_VEC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_exc_entry |=> branch && processing_mode_bit_o
		&& branch_pc == $past(vbase) + {20'h0_0000, $past(exc_offset_i)})
		else $error("exception branch target wrong");

	// Mode rises only through exception entry or reset
	AST_MODE_RISE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(processing_mode_bit_o) |-> $past(manual_rst_i)
		|| $past(exc_i || trap_i) || $past(sys_rst_i))
		else $error("privileged mode entered without exception");

	AST_USER_SYS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state == CMD_ST_RUN && !priv && !manual_rst_i && !exc_i && !trap_i
		&& (sys_instr_i || ctl_wr_i)) |=> priv_error
		&& $stable(status_word) && $stable(vbase))
		else $error("user mode executed protected operation");

	AST_SLEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state == CMD_ST_RUN && priv && sleep_i && !manual_rst_i && !exc_i
		&& !trap_i && !rte_i) |=> state == CMD_ST_SLEEP)
		else $error("sleep did not enter low power");

	// Privileged return restores the saved status word and PC
	sequence s_rte_priv;
		state == CMD_ST_RUN && rte_i && priv && !exc_i && !trap_i
		&& !manual_rst_i;
	endsequence
	AST_RTE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_rte_priv |=> branch && branch_pc == $past(saved_program_counter)
		&& status_word == $past(ssw))
		else $error("exception return did not restore context");

	// Low area follows the cache and translation enables
	AST_LOW_ATTR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state == CMD_ST_RUN && req_i.valid && !manual_rst_i
		&& !req_i.addr[AREA_HI]) |=> acc.valid && acc.ext_cycle
		&& acc.cacheable == $past(cache_en_i)
		&& acc.translate == $past(xlate_en_i))
		else $error("low area attributes wrong");

	// Cached direct area never translates
	AST_CDIR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state == CMD_ST_RUN && req_i.valid && !manual_rst_i && priv
		&& req_i.addr[AREA_HI:AREA_LO] == AREA_CACHED_DIRECT)
		|=> acc.valid && !acc.translate && acc.ext_cycle
		&& acc.cacheable == $past(cache_en_i))
		else $error("cached direct area attributes wrong");

endmodule

// ---- cmd_far_model.sv ----
// Purpose: Far-side model of cache and bus controller for the decoder.
// Assumes: Each valid access with ext_cycle starts one external cycle.
// Notes: Behavioural; answers at once, never stalls.
`timescale 1ns/1ps
module cmd_far_model
	import cmd_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire cmd_acc_t acc_i,
	output logic [15:0] ext_cnt_o,
	output logic [28:0] last_ext_o
);
	// Count external cycles and keep the last external address
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_cnt_o <= 16'h0000;
		end else if (acc_i.valid && acc_i.ext_cycle) begin
			ext_cnt_o <= ext_cnt_o + 16'h0001;
			last_ext_o <= acc_i.ext_addr;
		end
	end
endmodule

// ---- cmd_mode_decoder_bench.sv ----
// Purpose: Self-checking bench for the mode and address decoder.
// Assumes: Inputs change 1 ns after each rising clock edge.
// Notes: Each scenario is a task that drives and judges.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
	error_cnt++; \
	$display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module cmd_mode_decoder_bench
	import cmd_pkg::*;
;
	// Pulse index into pls
	localparam int EXC = 0, TRP = 1, EXCEPTION_RETURN_INSTRUCTION = 2, SLP = 3;
	localparam int WAK = 4, WR = 5, SYS = 6;
	// One address per area, low area top and area edges
	localparam logic [31:0] ADR [5] = '{32'h7FFF_FFFC, 32'h8000_0000,
		32'hBFFF_FFFC, 32'hC000_0100, 32'hE000_0010};
	logic clk_i, sys_rst_i, manual_rst_i, cache_en_i, xlate_en_i;
	cmd_req_t req_i;
	logic [11:0] exc_offset_i;
	logic [31:0] pc_i, ctl_wdata_i, branch_pc_o, status_word_o;
	logic [31:0] saved_program_counter_o, saved_status_word_o;
	logic [31:0] vector_base_o;
	logic [1:0] ctl_sel_i;
	logic [6:0] pls;
	cmd_acc_t acc_o;
	logic addr_error_o, priv_error_o, branch_o, processing_mode_bit_o;
	logic bsc_keep_o;
	cmd_state_t state_o;
	logic [15:0] ext_cnt;
	logic [28:0] last_ext;
	int error_cnt = 0;
	int n_compared = 0;

	cmd_mode_decoder dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.manual_rst_i(manual_rst_i), .req_i(req_i),
		.cache_en_i(cache_en_i), .xlate_en_i(xlate_en_i),
		.exc_i(pls[EXC]), .exc_offset_i(exc_offset_i), .pc_i(pc_i),
		.trap_i(pls[TRP]), .rte_i(pls[EXCEPTION_RETURN_INSTRUCTION]), .sleep_i(pls[SLP]),
		.wake_i(pls[WAK]), .ctl_wr_i(pls[WR]), .ctl_sel_i(ctl_sel_i),
		.ctl_wdata_i(ctl_wdata_i), .sys_instr_i(pls[SYS]),
		.acc_o(acc_o), .addr_error_o(addr_error_o),
		.priv_error_o(priv_error_o), .branch_o(branch_o),
		.branch_pc_o(branch_pc_o), .status_word_o(status_word_o),
		.saved_program_counter_o(saved_program_counter_o),
		.saved_status_word_o(saved_status_word_o),
		.vector_base_o(vector_base_o),
		.processing_mode_bit_o(processing_mode_bit_o),
		.bsc_keep_o(bsc_keep_o), .state_o(state_o));

	cmd_far_model far (.clk_i(clk_i), .rst_i(sys_rst_i), .acc_i(acc_o),
		.ext_cnt_o(ext_cnt), .last_ext_o(last_ext));

	// Free-running 100 ns clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// Verdict and end of run
	task automatic close_out();
		if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Wait one edge, then settle past it
	task automatic step();
		@(posedge clk_i);
		#1;
	endtask

	// One-cycle event pulse
	task automatic fire(input int k);
		pls[k] = 1'b1;
		step();
		pls[k] = 1'b0;
	endtask

	// Access request raised over one edge and left valid for the caller to drop
	task automatic req(input logic [31:0] a);
		req_i = '{1'b1, 1'b0, a};
		step();
	endtask

	// Expected {valid, cacheable, translate, ext_cycle, control}
	function automatic logic [4:0] attr(logic [31:0] a, logic c, logic x);
		case (a[31:29])
			AREA_CACHED_DIRECT: return {1'b1, c, 1'b0, 1'b1, 1'b0};
			AREA_UNCACHED_DIRECT: return 5'h12;
			AREA_CONTROL: return 5'h11;
			default: return {1'b1, c, x, 1'b1, 1'b0};
		endcase
	endfunction

	// Every area under all four enable settings, back to back
	task automatic t_areas();
		logic [15:0] n0;
		int ne;
		n0 = ext_cnt;
		ne = 0;
		for (int m = 0; m < 4; m++) begin
			cache_en_i = m[0];
			xlate_en_i = m[1];
			for (int i = 0; i < 5; i++) begin
				req(ADR[i]);
				`CHK(acc_o[33:29], attr(ADR[i], m[0], m[1]))
				if (ADR[i][31:29] != AREA_CONTROL) begin
					ne++;
					`CHK(acc_o.ext_addr, ADR[i][28:0])
				end
			end
		end
		req_i.valid = 1'b0;
		step();
		`CHK(ext_cnt - n0, 16'(ne))
		`CHK(last_ext, ADR[3][28:0])
	endtask

	// Exception entry from privileged mode
	task automatic t_exc();
		ctl_sel_i = CTL_SEL_VB;
		ctl_wdata_i = 32'h0000_1000;
		fire(WR);
		exc_offset_i = 12'h600;
		pc_i = 32'h0000_2468;
		fire(EXC);
		`CHK(branch_o, 1'b1)
		`CHK(branch_pc_o, 32'h0000_1600)
		`CHK(saved_program_counter_o, pc_i)
		`CHK(saved_status_word_o, SW_RESET)
		`CHK(processing_mode_bit_o, 1'b1)
		step();
		`CHK(state_o, CMD_ST_RUN)
		// Privileged writes of the saved registers
		ctl_sel_i = CTL_SEL_SPC;
		ctl_wdata_i = 32'h0000_4000;
		fire(WR);
		`CHK(saved_program_counter_o, 32'h0000_4000)
		step();
		ctl_sel_i = CTL_SEL_SSW;
		ctl_wdata_i = 32'h4000_00F0;
		fire(WR);
		`CHK(saved_status_word_o, 32'h4000_00F0)
	endtask

	// Sleep drops requests until woken
	task automatic t_sleep();
		fire(SLP);
		`CHK(state_o, CMD_ST_SLEEP)
		req(32'h0000_0100);
		`CHK(acc_o.valid, 1'b0)
		req_i.valid = 1'b0;
		fire(WAK);
		`CHK(state_o, CMD_ST_RUN)
	endtask

	// User mode protection, trap and return
	task automatic t_user();
		ctl_sel_i = CTL_SEL_SW;
		ctl_wdata_i = 32'h0000_00F0;
		fire(WR);
		`CHK(processing_mode_bit_o, 1'b0)
		req(32'hC000_0100);
		`CHK(addr_error_o, 1'b1)
		`CHK(acc_o, 34'h0)
		req(32'h0000_0100);
		`CHK({addr_error_o, acc_o.valid}, 2'h1)
		req_i.valid = 1'b0;
		fire(SYS);
		`CHK(priv_error_o, 1'b1)
		ctl_wdata_i = 32'h4000_00F0;
		fire(WR);
		`CHK({priv_error_o, processing_mode_bit_o}, 2'h2)
		fire(SLP);
		`CHK({priv_error_o, state_o}, {1'b1, CMD_ST_RUN})
		exc_offset_i = 12'h100;
		pc_i = 32'h0000_3000;
		fire(TRP);
		`CHK({branch_o, processing_mode_bit_o}, 2'h3)
		`CHK(branch_pc_o, 32'h0000_1100)
		`CHK(saved_status_word_o, 32'h0000_00F0)
		step();
		fire(EXCEPTION_RETURN_INSTRUCTION);
		`CHK(branch_pc_o, 32'h0000_3000)
		`CHK(status_word_o, 32'h0000_00F0)
	endtask

	// Manual reset out of user mode
	task automatic t_manual();
		manual_rst_i = 1'b1;
		step();
		step();
		manual_rst_i = 1'b0;
		`CHK(processing_mode_bit_o, 1'b1)
		step();
		`CHK({branch_o, branch_pc_o}, {1'b1, RESET_VECTOR})
		`CHK({bsc_keep_o, status_word_o}, {1'b1, SW_RESET})
		`CHK(vector_base_o, VBASE_RESET)
		// Reset handler area reached through the uncached direct window
		req(32'hA000_0100);
		`CHK(acc_o[33:29], 5'h12)
		`CHK(acc_o.ext_addr, 29'h000_0100)
		req_i.valid = 1'b0;
	endtask

	// Watchdog cuts a hang short
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end

	// Main sequence
	initial begin
		{sys_rst_i, manual_rst_i, cache_en_i, xlate_en_i} = 4'h8;
		req_i = '0;
		pls = 7'h00;
		exc_offset_i = 12'h000;
		pc_i = 32'h0;
		ctl_sel_i = 2'h0;
		ctl_wdata_i = 32'h0;
		repeat (3) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		`CHK({processing_mode_bit_o, bsc_keep_o}, 2'h2)
		step();
		`CHK({branch_o, branch_pc_o}, {1'b1, RESET_VECTOR})
		t_areas();
		t_exc();
		t_sleep();
		t_user();
		t_manual();
		close_out();
	end
endmodule
